/* File: ifl_ctrl.sv */
// Interrupt flag, enable and priority controller
// Functional notes
// R1: Compat mode: top bit gates every request
// R2: Priority mode: top bit is high global enable
// R3: Compat mode: second bit gates peripheral group
// R4: Priority mode: second bit gates low requests
// R5: Timer overflow sets sticky flag, enable bit5
// R6: External line A edge sets sticky flag
// R7: Upper port B change sets sticky flag
// R8: Mismatch keeps setting flag until port read
// R9: Port change needs per-pin change enable
// R10: Pullup disable bit forces all pullups off
// R11: Edge select bits: 1 rising, 0 falling
// R12: Timer and port change priority bits
// R13: Lines C and B priority bits
// R14: Lines C and B enable bits
// R15: Lines C and B sticky edge flags
// R16: Flags set regardless of any enable
// R17: Software clears flag before enabling source
// R18: Parallel slave access sets sticky flag
// R19: Conversion done sets sticky flag
// R20: Receive flag mirrors buffer full, read-only
// R21: Transmit flag mirrors buffer empty, read-only
// R22: Sync serial completion sets sticky flag
// R23: Priority mode bit, cleared after reset
// R24: Request needs flag, enable, global; vectors
// R25: Accept clears global enable, return sets
// R26: Registered separate high and low requests
//
// Local design decisions: the register addresses and the strobed register port.
module ifl_ctrl
  import ifl_pkg::*;
(
  input  wire logic        clock,                   // Core clock, 20 MHz
  input  wire logic        srst,                    // Synchronous reset, active high
  input  wire logic [3:0]  reg_addr,                // Register index
  input  wire logic [7:0]  reg_wdata,               // Write data
  input  wire logic        reg_wr,                  // Write strobe
  input  wire logic        reg_rd,                  // Read strobe
  output logic      [7:0]  reg_rdata,               // Read data, cycle after strobe
  input  wire logic        timer_zero_ovf,          // Timer overflow pulse
  input  wire logic [2:0]  ext_line_pins,           // External lines C, B, A
  input  wire logic [3:0]  port_b_pins,             // Port B pins 7..4
  input  wire logic [7:0]  port_b_is_input,         // Port B direction, 1 input
  input  wire logic        parallel_slave_access,   // Parallel port access pulse
  input  wire logic        conversion_done,         // Conversion done pulse
  input  wire logic        serial_rx_full,          // Receive buffer holds data
  input  wire logic        serial_tx_empty,         // Transmit buffer empty
  input  wire logic        sync_serial_done,        // Sync serial done pulse
  input  wire logic        core_accept,             // Core takes an interrupt
  input  wire logic        core_accept_high,        // Taken level is high
  input  wire logic        core_return,             // Return from interrupt
  input  wire logic        core_return_high,        // Returning from high level
  output logic             req_high,                // High priority request
  output logic             req_low,                 // Low priority request
  output logic      [15:0] irq_vector,              // Vector of pending request
  output logic      [7:0]  pullup_en                // Port B pullup drive
);
  // Software visible state
  logic                 global_or_high_enable;
  logic                 periph_or_low_enable;
  logic [2:0]           core_src_en;       // Timer, line A, port change
  logic [7:0]           edge_reg;
  logic [7:0]           ext_ctl;
  logic [7:0]           periph_en;
  logic [7:0]           periph_pri;
  logic [7:0]           mode_reg;
  logic [3:0]           per_pin_change_enables;
  logic [7:0]           per_pin_pullup_enables;
  logic [3:0]           port_latch;
  logic                 serial_rx_full_flag;
  logic                 serial_tx_empty_flag;

  // Decoded strobes
  wire wr_main = reg_wr & (reg_addr == ADDR_MAIN);
  wire wr_edge = reg_wr & (reg_addr == ADDR_EDGE);
  wire wr_ext  = reg_wr & (reg_addr == ADDR_EXT);
  wire wr_pflg = reg_wr & (reg_addr == ADDR_PFLG);
  wire wr_pen  = reg_wr & (reg_addr == ADDR_PEN);
  wire wr_ppri = reg_wr & (reg_addr == ADDR_PPRI);
  wire wr_mode = reg_wr & (reg_addr == ADDR_MODE);
  wire wr_chg  = reg_wr & (reg_addr == ADDR_CHG);
  wire wr_pull = reg_wr & (reg_addr == ADDR_PULL);
  wire rd_port = reg_rd & (reg_addr == ADDR_PORT);

  // Named control fields
  wire priority_mode_enable    = mode_reg[MODE_PRIO];         // R23
  wire port_pullup_disable     = edge_reg[EDG_PU_DIS];
  wire timer_zero_ovf_enable   = core_src_en[2];
  wire ext_line_a_enable       = core_src_en[1];
  wire port_change_enable      = core_src_en[0];
  wire ext_line_c_enable       = ext_ctl[EXT_CIE];            // R14
  wire ext_line_b_enable       = ext_ctl[EXT_BIE];            // R14
  wire timer_zero_ovf_priority = edge_reg[EDG_T0IP];          // R12
  wire port_change_priority    = edge_reg[EDG_PORT_CHANGE_PRIORITY];          // R12
  wire ext_line_c_priority     = ext_ctl[EXT_CIP];            // R13
  wire ext_line_b_priority     = ext_ctl[EXT_BIP];            // R13

  // External line synchronisers, edge selects C, B, A
  logic [2:0] ext_level;
  logic [2:0] ext_edge;
  wire  [2:0] ext_sel = {edge_reg[EDG_SEL_C], edge_reg[EDG_SEL_B], edge_reg[EDG_SEL_A]}; // R11

  ifl_sync_edge #(.W(3)) u_ext_sync (
    .clock    (clock),
    .srst     (srst),
    .pin_in   (ext_line_pins),
    .edge_sel (ext_sel),
    .level    (ext_level),
    .edge_hit (ext_edge)
  );

  // Port B synchronisers, only the level is used
  logic [3:0] port_b_data;

  ifl_sync_edge #(.W(4)) u_port_sync (
    .clock    (clock),
    .srst     (srst),
    .pin_in   (port_b_pins),
    .edge_sel (4'h0),
    .level    (port_b_data),
    .edge_hit ()
  );

  // Mismatch against the last value software read, enabled pins only
  wire port_mismatch = |((port_b_data ^ port_latch) & per_pin_change_enables); // R9

  // Sticky flag store
  ifl_flag_if #(.W(NUM_FLAGS)) flag_bus ();

  ifl_flag_store #(.W(NUM_FLAGS)) u_flags (
    .clock (clock),
    .srst  (srst),
    .fl    (flag_bus.store)
  );

  // Hardware events set flags whatever the enables
  assign flag_bus.set_ev[FL_T0]   = timer_zero_ovf;            // R5 R16
  assign flag_bus.set_ev[FL_E0]   = ext_edge[0];               // R6
  assign flag_bus.set_ev[FL_RB]   = port_mismatch;             // R7 R8
  assign flag_bus.set_ev[FL_E1]   = ext_edge[1];               // R15
  assign flag_bus.set_ev[FL_E2]   = ext_edge[2];               // R15
  assign flag_bus.set_ev[FL_PSP]  = parallel_slave_access;     // R18
  assign flag_bus.set_ev[FL_CONV] = conversion_done;           // R19
  assign flag_bus.set_ev[FL_SSP]  = sync_serial_done;          // R22

  // Software writes to flags, per register
  assign flag_bus.wr_en[FL_T0]   = wr_main;
  assign flag_bus.wr_en[FL_E0]   = wr_main;
  assign flag_bus.wr_en[FL_RB]   = wr_main;
  assign flag_bus.wr_en[FL_E1]   = wr_ext;
  assign flag_bus.wr_en[FL_E2]   = wr_ext;
  assign flag_bus.wr_en[FL_PSP]  = wr_pflg;
  assign flag_bus.wr_en[FL_CONV] = wr_pflg;
  assign flag_bus.wr_en[FL_SSP]  = wr_pflg;
  assign flag_bus.wr_data[FL_T0]   = reg_wdata[MAIN_T0IF];
  assign flag_bus.wr_data[FL_E0]   = reg_wdata[MAIN_E0IF];
  assign flag_bus.wr_data[FL_RB]   = reg_wdata[MAIN_PORT_CHANGE_FLAG];
  assign flag_bus.wr_data[FL_E1]   = reg_wdata[EXT_BIF];
  assign flag_bus.wr_data[FL_E2]   = reg_wdata[EXT_CIF];
  assign flag_bus.wr_data[FL_PSP]  = reg_wdata[PF_PSP];
  assign flag_bus.wr_data[FL_CONV] = reg_wdata[PF_CONV];
  assign flag_bus.wr_data[FL_SSP]  = reg_wdata[PF_SSP];

  wire [7:0] fl = flag_bus.flags;
  wire timer_zero_ovf_flag = fl[FL_T0];
  wire ext_line_a_flag     = fl[FL_E0];
  wire port_change_flag    = fl[FL_RB];

  // Source vectors: bits 0..4 core group, 5..9 peripheral group
  wire [9:0] src_flag = {fl[FL_PSP], fl[FL_CONV], serial_rx_full_flag, serial_tx_empty_flag,
                         fl[FL_SSP], fl[FL_E2], fl[FL_E1], port_change_flag,
                         ext_line_a_flag, timer_zero_ovf_flag};
  wire [9:0] src_en   = {periph_en[PF_PSP], periph_en[PF_CONV], periph_en[PF_RX],
                         periph_en[PF_TX], periph_en[PF_SSP], ext_line_c_enable,
                         ext_line_b_enable, port_change_enable, ext_line_a_enable,
                         timer_zero_ovf_enable};
  wire [9:0] src_pri  = {periph_pri[PF_PSP], periph_pri[PF_CONV], periph_pri[PF_RX],
                         periph_pri[PF_TX], periph_pri[PF_SSP], ext_line_c_priority,
                         ext_line_b_priority, port_change_priority, 1'b1,
                         timer_zero_ovf_priority};
  wire [9:0] src_act  = src_flag & src_en;                     // R24

  // Compatibility mode combining
  wire core_any   = |(src_act & ~SRC_PERIPH);
  wire periph_any = |(src_act & SRC_PERIPH);
  wire compat_req = global_or_high_enable &
                    (core_any | (periph_or_low_enable & periph_any)); // R1 R3

  // Priority mode combining
  wire prio_high = global_or_high_enable & |(src_act & src_pri);     // R2
  wire prio_low  = global_or_high_enable & periph_or_low_enable &
                   |(src_act & ~src_pri);                            // R2 R4

  wire next_req_high = priority_mode_enable ? prio_high : compat_req; // R23
  wire next_req_low  = priority_mode_enable & prio_low;
  wire [15:0] next_irq_vector = (!next_req_high && next_req_low) ? VEC_LOW : VEC_HIGH; // R24

  // Global enables: accept clears, return sets, write in between
  wire acc_high = core_accept & (~priority_mode_enable | core_accept_high);
  wire acc_low  = core_accept & priority_mode_enable & ~core_accept_high;
  wire ret_high = core_return & (~priority_mode_enable | core_return_high);
  wire ret_low  = core_return & priority_mode_enable & ~core_return_high;
  wire next_global_or_high_enable =
    acc_high ? 1'b0 : ret_high ? 1'b1 :
    wr_main ? reg_wdata[MAIN_GEH] : global_or_high_enable;       // R25
  wire next_periph_or_low_enable =
    acc_low ? 1'b0 : ret_low ? 1'b1 :
    wr_main ? reg_wdata[MAIN_GEL] : periph_or_low_enable;        // R25

  // Pullup drive
  wire [7:0] next_pullup_en = port_pullup_disable ? 8'h00
                            : (per_pin_pullup_enables & port_b_is_input); // R10

  // Read views
  wire [7:0] view_main = {global_or_high_enable, periph_or_low_enable, core_src_en,
                          timer_zero_ovf_flag, ext_line_a_flag, port_change_flag};
  wire [7:0] view_ext  = (ext_ctl & EXT_CTL_MASK) |
                         {6'h00, fl[FL_E2], fl[FL_E1]};
  wire [7:0] view_pflg = {fl[FL_PSP], fl[FL_CONV], serial_rx_full_flag,
                          serial_tx_empty_flag, fl[FL_SSP], 3'h0};
  wire [7:0] rd_value =
    (reg_addr == ADDR_MAIN) ? view_main :
    (reg_addr == ADDR_EDGE) ? (edge_reg & EDGE_MASK) :
    (reg_addr == ADDR_EXT)  ? view_ext :
    (reg_addr == ADDR_PFLG) ? view_pflg :
    (reg_addr == ADDR_PEN)  ? (periph_en & PERI_MASK) :
    (reg_addr == ADDR_PPRI) ? (periph_pri & PERI_MASK) :
    (reg_addr == ADDR_MODE) ? mode_reg :
    (reg_addr == ADDR_CHG)  ? {per_pin_change_enables, 4'h0} :
    (reg_addr == ADDR_PULL) ? per_pin_pullup_enables :
    (reg_addr == ADDR_PORT) ? {port_b_data, 4'h0} : 8'h00;

  // Global enables
  always_ff @(posedge clock) begin
    if (srst) begin
      global_or_high_enable <= RST_MAIN[MAIN_GEH];
      periph_or_low_enable  <= RST_MAIN[MAIN_GEL];
    end else begin
      global_or_high_enable <= next_global_or_high_enable;
      periph_or_low_enable  <= next_periph_or_low_enable;
    end
  end

  // Control registers
  always_ff @(posedge clock) begin
    if (srst) begin
      core_src_en            <= RST_MAIN[MAIN_T0IE:MAIN_PORT_CHANGE_ENABLE];
      edge_reg               <= RST_EDGE;
      ext_ctl                <= RST_EXT;
      periph_en              <= RST_PEN;
      periph_pri             <= RST_PPRI;
      mode_reg               <= RST_MODE;
      per_pin_change_enables <= RST_CHG;
      per_pin_pullup_enables <= RST_PULL;
    end else begin
      if (wr_main) core_src_en <= reg_wdata[MAIN_T0IE:MAIN_PORT_CHANGE_ENABLE];
      if (wr_edge) edge_reg <= reg_wdata & EDGE_MASK;
      if (wr_ext)  ext_ctl <= reg_wdata & EXT_CTL_MASK;
      if (wr_pen)  periph_en <= reg_wdata & PERI_MASK;
      if (wr_ppri) periph_pri <= reg_wdata & PERI_MASK;
      if (wr_mode) mode_reg <= reg_wdata & (8'h01 << MODE_PRIO);
      if (wr_chg)  per_pin_change_enables <= reg_wdata[7:4];
      if (wr_pull) per_pin_pullup_enables <= reg_wdata;
    end
  end

  // Port read ends the mismatch; serial flags mirror their units
  always_ff @(posedge clock) begin
    if (srst) begin
      port_latch           <= 4'h0;
      serial_rx_full_flag  <= 1'b0;
      serial_tx_empty_flag <= 1'b0;
    end else begin
      if (rd_port) port_latch <= port_b_data;  // R8
      serial_rx_full_flag  <= serial_rx_full;  // R20
      serial_tx_empty_flag <= serial_tx_empty; // R21
    end
  end

  // Registered outputs
  always_ff @(posedge clock) begin
    if (srst) begin
      req_high   <= 1'b0;
      req_low    <= 1'b0;
      irq_vector <= VEC_HIGH;
      pullup_en  <= 8'h00;
      reg_rdata  <= 8'h00;
    end else begin
      req_high   <= next_req_high;                 // R26
      req_low    <= next_req_low;                  // R26
      irq_vector <= next_irq_vector;
      pullup_en  <= next_pullup_en;
      reg_rdata  <= reg_rd ? rd_value : 8'h00;
    end
  end

  // Checks on the controller
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  a_top_blocks_all: assert property ( // R1 R2
    !global_or_high_enable |=> !req_high && !req_low)
    else $error("Request while top enable clear");

  a_compat_no_low: assert property ( // R23
    !priority_mode_enable |=> !req_low)
    else $error("Low request in compatibility mode");

  a_periph_gated: assert property ( // R3
    !priority_mode_enable && !periph_or_low_enable && !core_any |=> !req_high)
    else $error("Peripheral request passed while gated");

  a_low_gated: assert property ( // R4
    priority_mode_enable && !periph_or_low_enable |=> !req_low)
    else $error("Low request while low enable clear");

  a_timer_sets: assert property ( // R5 R16
    timer_zero_ovf |=> timer_zero_ovf_flag ##1 (timer_zero_ovf_flag || $past(wr_main)))
    else $error("Timer flag not set or not held");

  a_mismatch_sets: assert property ( // R8 R9
    port_mismatch && !rd_port |=> port_change_flag)
    else $error("Port change flag not set on mismatch");

  a_rx_mirror: assert property ( // R20
    serial_rx_full |=> serial_rx_full_flag)
    else $error("Receive flag does not follow buffer");

  a_accept_clears: assert property ( // R25
    core_accept && !priority_mode_enable |=> !global_or_high_enable)
    else $error("Global enable not cleared on accept");

  a_low_vector: assert property ( // R24
    req_low && !req_high |-> irq_vector == VEC_LOW)
    else $error("Low request without low vector");

  a_pullup_off: assert property ( // R10
    port_pullup_disable |=> pullup_en == 8'h00)
    else $error("Pullup driven while disabled");

  a_high_req_cause: assert property ( // R24
    $rose(req_high) |-> ($past(src_act) != 10'h000) && $past(global_or_high_enable))
    else $error("High request without cause");

  c_high_req: cover property (priority_mode_enable && req_high);
  c_low_req: cover property (req_low);
  c_preempt: cover property (req_low ##[1:20] req_high && !periph_or_low_enable);
  c_port_clear: cover property (rd_port ##[1:4] wr_main ##1 !port_change_flag);
endmodule : ifl_ctrl

/* File: ifl_flag_if.sv */
// Carrier between the controller and its sticky flag store
interface ifl_flag_if #(parameter int W = 8);
  logic [W-1:0] set_ev;   // Hardware set events
  logic [W-1:0] wr_en;    // Per-bit software write enable
  logic [W-1:0] wr_data;  // Software write value
  logic [W-1:0] flags;    // Stored flags

  modport store (input set_ev, input wr_en, input wr_data, output flags);
  modport ctl   (output set_ev, output wr_en, output wr_data, input flags);
endinterface : ifl_flag_if

/* File: ifl_flag_store.sv */
// Sticky interrupt flags, hardware set wins over software write
module ifl_flag_store #(
  parameter int W = 8
) (
  input wire logic clock,  // Core clock
  input wire logic srst,   // Synchronous reset, active high
  ifl_flag_if.store fl     // Flag set and write carrier
);
  // Set beats a same-cycle clear
  always_ff @(posedge clock) begin
    if (srst) begin
      fl.flags <= '0;
    end else begin
      fl.flags <= (fl.flags & ~fl.wr_en) | (fl.wr_data & fl.wr_en) | fl.set_ev;
    end
  end
endmodule : ifl_flag_store

/* File: ifl_pkg.sv */
// Constants shared by the interrupt flag, enable and priority logic
package ifl_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [3:0] ADDR_MAIN = 4'h0;
  localparam logic [3:0] ADDR_EDGE = 4'h1;
  localparam logic [3:0] ADDR_EXT  = 4'h2;
  localparam logic [3:0] ADDR_PFLG = 4'h3;
  localparam logic [3:0] ADDR_PEN  = 4'h4;
  localparam logic [3:0] ADDR_PPRI = 4'h5;
  localparam logic [3:0] ADDR_MODE = 4'h6;
  localparam logic [3:0] ADDR_CHG  = 4'h7;
  localparam logic [3:0] ADDR_PULL = 4'h8;
  localparam logic [3:0] ADDR_PORT = 4'h9;

  // Field positions
  localparam int MAIN_GEH = 7, MAIN_GEL = 6, MAIN_T0IE = 5, MAIN_E0IE = 4, MAIN_PORT_CHANGE_ENABLE = 3;
  localparam int MAIN_T0IF = 2, MAIN_E0IF = 1, MAIN_PORT_CHANGE_FLAG = 0;
  localparam int EDG_PU_DIS = 7, EDG_SEL_A = 6, EDG_SEL_B = 5, EDG_SEL_C = 4;
  localparam int EDG_T0IP = 2, EDG_PORT_CHANGE_PRIORITY = 0;
  localparam int EXT_CIP = 7, EXT_BIP = 6, EXT_CIE = 4, EXT_BIE = 3, EXT_CIF = 1, EXT_BIF = 0;
  localparam int PF_PSP = 7, PF_CONV = 6, PF_RX = 5, PF_TX = 4, PF_SSP = 3;
  localparam int MODE_PRIO = 7;

  // Reset values and writable masks
  localparam logic [7:0] RST_MAIN = 8'h00;
  localparam logic [7:0] RST_EDGE = 8'hf5;
  localparam logic [7:0] RST_EXT  = 8'hc0;
  localparam logic [7:0] RST_PEN  = 8'h00;
  localparam logic [7:0] RST_PPRI = 8'hf8;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [3:0] RST_CHG  = 4'h0;
  localparam logic [7:0] RST_PULL = 8'h00;
  localparam logic [7:0] EDGE_MASK = 8'hf5;
  localparam logic [7:0] EXT_CTL_MASK = 8'hd8;
  localparam logic [7:0] PERI_MASK = 8'hf8;

  // Sticky flag slots
  localparam int NUM_FLAGS = 8;
  localparam int FL_T0 = 0, FL_E0 = 1, FL_RB = 2, FL_E1 = 3, FL_E2 = 4;
  localparam int FL_PSP = 5, FL_CONV = 6, FL_SSP = 7;

  // Request sources: 0..4 core group, 5..9 peripheral group
  localparam int NUM_SRC = 10;
  localparam logic [9:0] SRC_PERIPH = 10'h3e0;

  // Interrupt vectors
  localparam logic [15:0] VEC_HIGH = 16'h0008;
  localparam logic [15:0] VEC_LOW  = 16'h0018;
endpackage : ifl_pkg

/* File: ifl_src_model.sv */
// Model of the interrupt sources and of the processor core beside the controller
module ifl_src_model (
  input  wire logic       clock,                  // Core clock
  input  wire logic       srst,                   // Synchronous reset, active high
  input  wire logic [5:0] cmd,                    // Return, accept, sync, conv, slave, timer
  input  wire logic       req_high,               // High request from controller
  input  wire logic       req_low,                // Low request from controller
  output logic            timer_zero_ovf,         // Timer overflow pulse
  output logic            parallel_slave_access,  // Parallel port access pulse
  output logic            conversion_done,        // Conversion done pulse
  output logic            sync_serial_done,       // Sync serial done pulse
  output logic            core_accept,            // Core takes a pending request
  output logic            core_accept_high,       // Taken level
  output logic            core_return,            // Return from service
  output logic            core_return_high        // Returning from high level
);
  // Event pulses last one cycle; the core only takes a request that is really pending
  // and a return reports the level that was last taken
  always_ff @(posedge clock) begin
    if (srst) begin
      {core_return, core_accept, sync_serial_done} <= 3'h0;
      {conversion_done, parallel_slave_access, timer_zero_ovf} <= 3'h0;
      core_return_high <= 1'b1;
    end else begin
      {sync_serial_done, conversion_done, parallel_slave_access, timer_zero_ovf} <= cmd[3:0];
      core_accept <= cmd[4] && (req_high || req_low);
      core_return <= cmd[5];
      if (core_accept) core_return_high <= core_accept_high;
    end
    core_accept_high <= req_high;
  end
endmodule : ifl_src_model

/* File: ifl_sync_edge.sv */
// Two-stage pin synchronisers with selectable edge detection
module ifl_sync_edge #(
  parameter int W = 3
) (
  input  wire logic         clock,     // Core clock
  input  wire logic         srst,      // Synchronous reset, active high
  input  wire logic [W-1:0] pin_in,    // Asynchronous pins
  input  wire logic [W-1:0] edge_sel,  // 1 rising, 0 falling
  output logic      [W-1:0] level,     // Synchronised level
  output logic      [W-1:0] edge_hit   // One-cycle selected edge
);
  logic [W-1:0] stage_a;
  logic [W-1:0] prev;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // Sync chain and previous sample per pin
      always_ff @(posedge clock) begin
        if (srst) begin
          stage_a[i] <= 1'b0;
          level[i]   <= 1'b0;
          prev[i]    <= 1'b0;
        end else begin
          stage_a[i] <= pin_in[i];
          level[i]   <= stage_a[i];
          prev[i]    <= level[i];
        end
      end
      assign edge_hit[i] = edge_sel[i] ? (level[i] & ~prev[i]) : (~level[i] & prev[i]);
    end
  endgenerate
endmodule : ifl_sync_edge

/* File: testbench.sv */
// Self-checking bench for the interrupt flag, enable and priority controller
module testbench
  import ifl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0]  reg_addr = 4'h0, port_b_pins = 4'h0;
  logic [7:0]  reg_wdata = 8'h00, is_in = 8'h00, reg_rdata, pullup_en, d;
  logic [2:0]  ext_pins = 3'h0;
  logic [5:0]  cmd = 6'h00;
  logic        rx_full = 1'b0, tx_empty = 1'b0, req_high, req_low;
  logic        tmo, psa, cdn, ssd, acc, acc_h, rtn, rtn_h;
  logic [15:0] irq_vector;
  logic [31:0] lfsr = 32'h00012ef3;
  int          error_cnt = 0;
  int          n_checks = 0;

  ifl_ctrl i_ifl_ctrl (.clock(clock), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .timer_zero_ovf(tmo), .ext_line_pins(ext_pins), .port_b_pins(port_b_pins),
    .port_b_is_input(is_in), .parallel_slave_access(psa), .conversion_done(cdn),
    .serial_rx_full(rx_full), .serial_tx_empty(tx_empty), .sync_serial_done(ssd),
    .core_accept(acc), .core_accept_high(acc_h), .core_return(rtn),
    .core_return_high(rtn_h), .req_high(req_high), .req_low(req_low),
    .irq_vector(irq_vector), .pullup_en(pullup_en));
  ifl_src_model i_ifl_src_model (.clock(clock), .srst(srst), .cmd(cmd),
    .req_high(req_high), .req_low(req_low), .timer_zero_ovf(tmo),
    .parallel_slave_access(psa), .conversion_done(cdn), .sync_serial_done(ssd),
    .core_accept(acc), .core_accept_high(acc_h), .core_return(rtn),
    .core_return_high(rtn_h));

  // Clock and watchdog
  always #25 clock = ~clock;
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    print_verdict();
  end

  // Random source and expected pull-up drive
  function automatic logic [31:0] next_lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_lfsr
  function automatic logic [7:0] exp_pull(input logic [7:0] en, input logic [7:0] inp,
                                          input logic dis);
    return dis ? 8'h00 : (en & inp);
  endfunction : exp_pull

  // Compare, verdict and bus tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk({8'h00, reg_rdata}, {8'h00, v});
  endtask : rd
  task automatic pulse(input logic [5:0] c);
    @(posedge clock);
    cmd <= c;
    @(posedge clock);
    cmd <= 6'h00;
    repeat (3) @(posedge clock);
  endtask : pulse
  task automatic wait_req(input logic hi, input logic v);
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      #1;
      if ((hi ? req_high : req_low) === v) break;
    end
    chk({15'h0000, hi ? req_high : req_low}, {15'h0000, v});
    if ((hi ? req_high : req_low) !== v) print_verdict();
  endtask : wait_req

  // Main sequence
  initial begin
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    rd(ADDR_EDGE, 8'hf5); rd(ADDR_EXT, 8'hc0); rd(ADDR_MODE, 8'h00);
    rd(4'hf, 8'h00);
    pulse(6'h01);
    rd(ADDR_MAIN, 8'h04);
    wr(ADDR_MAIN, 8'h20);
    pulse(6'h01);
    wait_req(1'b1, 1'b0);
    wr(ADDR_MAIN, 8'ha4);
    wait_req(1'b1, 1'b1);
    chk(irq_vector, 16'h0008);
    pulse(6'h10);
    rd(ADDR_MAIN, 8'h24);
    pulse(6'h20);
    rd(ADDR_MAIN, 8'ha4);
    wr(ADDR_MAIN, 8'h80); wr(ADDR_PEN, 8'h40);
    pulse(6'h04);
    wait_req(1'b1, 1'b0);
    wr(ADDR_MAIN, 8'hc0);
    wait_req(1'b1, 1'b1);
    wr(ADDR_MODE, 8'h80); wr(ADDR_PPRI, 8'h00); wr(ADDR_MAIN, 8'h80);
    wait_req(1'b0, 1'b0);
    wr(ADDR_MAIN, 8'hc0);
    wait_req(1'b0, 1'b1);
    chk(irq_vector, 16'h0018);
    pulse(6'h10); rd(ADDR_MAIN, 8'h80);
    pulse(6'h20); rd(ADDR_MAIN, 8'hc0);
    wr(ADDR_MAIN, 8'h40);
    wait_req(1'b0, 1'b0);
    wr(ADDR_PPRI, 8'h40); wr(ADDR_MAIN, 8'h80);
    wait_req(1'b1, 1'b1);
    wr(ADDR_MODE, 8'h00); wr(ADDR_MAIN, 8'h00); wr(ADDR_PFLG, 8'hff);
    rd(ADDR_PFLG, 8'hc8);
    wr(ADDR_PFLG, 8'h00);
    pulse(6'h0e);
    rd(ADDR_PFLG, 8'hc8);
    wr(ADDR_PFLG, 8'h00);
    rx_full <= 1'b1;
    tx_empty <= 1'b1;
    rd(ADDR_PFLG, 8'h30);
    // External lines: rising then falling edges
    wr(ADDR_EDGE, 8'h70);
    ext_pins <= 3'h7;
    repeat (4) @(posedge clock);
    rd(ADDR_MAIN, 8'h02); rd(ADDR_EXT, 8'hc3);
    wr(ADDR_EXT, 8'h18); wr(ADDR_MAIN, 8'h80);
    wait_req(1'b1, 1'b0);
    wr(ADDR_EDGE, 8'h00);
    ext_pins <= 3'h0;
    wait_req(1'b1, 1'b1);
    // Port change with per-pin enable and mismatch latch
    wr(ADDR_EXT, 8'h00); wr(ADDR_MAIN, 8'h00); wr(ADDR_CHG, 8'h10);
    port_b_pins <= 4'h2;
    repeat (4) @(posedge clock);
    rd(ADDR_MAIN, 8'h00);
    port_b_pins <= 4'h3;
    repeat (4) @(posedge clock);
    rd(ADDR_MAIN, 8'h01);
    wr(ADDR_MAIN, 8'h00);
    rd(ADDR_MAIN, 8'h01);
    rd(ADDR_PORT, 8'h30);
    wr(ADDR_MAIN, 8'h00);
    rd(ADDR_MAIN, 8'h00);
    // Random control values, read back and pull-up drive
    for (int i = 0; i < 6; i++) begin
      lfsr = next_lfsr(next_lfsr(lfsr));
      d = lfsr[23:16];
      is_in <= lfsr[7:0];
      wr(ADDR_PULL, lfsr[15:8]); wr(ADDR_EDGE, d); wr(ADDR_EXT, lfsr[31:24]);
      rd(ADDR_EDGE, d & 8'hf5);
      rd(ADDR_EXT, lfsr[31:24] & 8'hdb);
      chk({8'h00, pullup_en}, {8'h00, exp_pull(lfsr[15:8], lfsr[7:0], d[7])});
    end
    print_verdict();
  end
endmodule : testbench
